// file: core/cal_regs_pkg.sv
// Constants and carrier types for the calibration and threshold register bank.
// Assumes a 24-bit register word addressed by page number and word address.
package cal_regs_pkg;

  localparam int unsigned DATA_W = 24;
  localparam int unsigned PAGE_W = 8;
  localparam int unsigned ADDR_W = 6;

  localparam logic [PAGE_W-1:0] PAGE_0 = 8'h00;
  localparam logic [PAGE_W-1:0] PAGE_16 = 8'h10;
  localparam logic [PAGE_W-1:0] PAGE_18 = 8'h12;

  localparam logic [ADDR_W-1:0] ADDR_CURRENT_ZX_THRESHOLD = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_CURRENT_GAIN = 6'h21;
  localparam logic [ADDR_W-1:0] ADDR_CURRENT_AC_OFFSET = 6'h25;
  localparam logic [ADDR_W-1:0] ADDR_REACTIVE_POWER_OFFSET = 6'h26;
  localparam logic [ADDR_W-1:0] ADDR_TEMPERATURE_GAIN = 6'h36;
  localparam logic [ADDR_W-1:0] ADDR_TEMPERATURE_OFFSET = 6'h37;
  localparam logic [ADDR_W-1:0] ADDR_ZERO_CROSS_COUNT = 6'h37;
  localparam logic [ADDR_W-1:0] ADDR_VOLTAGE_ZX_THRESHOLD = 6'h3a;
  localparam logic [ADDR_W-1:0] ADDR_CALIBRATION_SCALE = 6'h3f;

  localparam logic [DATA_W-1:0] RST_ZX_THRESHOLD = 24'h100000;
  localparam logic [DATA_W-1:0] RST_CURRENT_GAIN = 24'h400000;
  localparam logic [DATA_W-1:0] RST_CURRENT_AC_OFFSET = 24'h000000;
  localparam logic [DATA_W-1:0] RST_REACTIVE_POWER_OFFSET = 24'h000000;
  localparam logic [DATA_W-1:0] RST_TEMPERATURE_GAIN = 24'h06b716;
  localparam logic [DATA_W-1:0] RST_TEMPERATURE_OFFSET = 24'hd53998;
  localparam logic [DATA_W-1:0] RST_ZERO_CROSS_COUNT = 24'h000064;
  localparam logic [DATA_W-1:0] RST_CALIBRATION_SCALE = 24'h4ccccc;

  // Fraction bits of the fixed-point formats involved in arithmetic.
  localparam int unsigned TEMP_GAIN_FRAC = 16;
  localparam int unsigned GAIN_FRAC = 22;
  localparam int unsigned DIV_W = DATA_W + GAIN_FRAC;
  localparam logic [DATA_W-1:0] GAIN_MAX = 24'hffffff;

  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } reg_write_t;

  typedef enum logic [0:0] {
    CAL_IDLE,
    CAL_DIVIDE
  } cal_state_t;

endpackage : cal_regs_pkg

// file: core/calibration_threshold_regs.sv
// Calibration and threshold register bank of a two-channel energy front end.
// Assumes the serial port decoder presents one-cycle write and read strobes
// with page and word address, and that datapath inputs are on i_clk.
//
// Function
// - Reactive power offset, reset zero, is added to averaged reactive power.
// - Current AC offset clears at reset and is subtracted from the squared RMS.
// - Temperature gain, unsigned 8.16, resets to 0x06B716, scales temperature.
// - Temperature offset, signed 8.16, resets to 0xD53998, offsets temperature.
// - Gain calibration divides scale by current RMS into current gain.
// - Calibration scale resets to 0x4CCCCC, which is 0.6.
// - Line frequency window spans zero-crossing count crossings, reset 100.
// - Voltage zero-crossing detection only while peak voltage exceeds threshold.
// - Current zero-crossing detection only while peak current exceeds threshold.
// - Current gain is unsigned 2.22, range below 4.0, resets to 1.0.
// - Data-ready flag sets when a calibration command completes.
`timescale 1ns/100ps
module calibration_threshold_regs
  import cal_regs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire reg_write_t i_wr_req,
  input wire logic i_rd,
  input wire logic [PAGE_W-1:0] i_rd_page,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  input wire logic [DATA_W-1:0] i_reactive_power_raw,
  input wire logic [DATA_W-1:0] i_current_rms_sq,
  input wire logic [DATA_W-1:0] i_current_rms_result,
  input wire logic [DATA_W-1:0] i_temperature_raw,
  input wire logic [DATA_W-1:0] i_voltage_peak,
  input wire logic [DATA_W-1:0] i_current_peak,
  input wire logic i_zero_cross,
  input wire logic i_cal_gain_start,
  input wire logic i_data_ready_clear,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_reactive_power_average,
  output logic [DATA_W-1:0] o_current_rms_corrected,
  output logic [DATA_W-1:0] o_temperature_result,
  output logic [DATA_W-1:0] o_current_gain,
  output logic o_voltage_zx_enable,
  output logic o_current_zx_enable,
  output logic o_freq_window_done,
  output logic o_cal_busy,
  output logic o_data_ready_flag
);

  function automatic logic hit(input logic [PAGE_W-1:0] pg, input logic [ADDR_W-1:0] ad,
                               input logic [PAGE_W-1:0] want_pg, input logic [ADDR_W-1:0] want_ad);
    hit = (pg == want_pg) && (ad == want_ad);
  endfunction : hit

  logic [DATA_W-1:0] reactive_power_offset_ff;
  logic [DATA_W-1:0] current_ac_offset_ff;
  logic [DATA_W-1:0] temperature_gain_ff;
  logic [DATA_W-1:0] temperature_offset_ff;
  logic [DATA_W-1:0] calibration_scale_ff;
  logic [DATA_W-1:0] zero_cross_count_ff;
  logic [DATA_W-1:0] voltage_zero_cross_threshold_ff;
  logic [DATA_W-1:0] current_zero_cross_threshold_ff;
  logic [DATA_W-1:0] current_gain_ff;
  logic [DATA_W-1:0] zx_seen_ff;
  logic freq_done_ff;
  logic data_ready_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic rd_valid_ff;
  cal_state_t state_ff;
  logic [DIV_W-1:0] dividend_ff;
  logic [DATA_W:0] remainder_ff;
  logic [DIV_W-1:0] quotient_ff;
  logic [$clog2(DIV_W+1)-1:0] bit_cnt_ff;

  wire [PAGE_W-1:0] wpg = i_wr_req.page;
  wire [ADDR_W-1:0] wad = i_wr_req.addr;
  wire wr_reactive_off = i_wr && hit(wpg, wad, PAGE_16, ADDR_REACTIVE_POWER_OFFSET);
  wire wr_ac_off = i_wr && hit(wpg, wad, PAGE_16, ADDR_CURRENT_AC_OFFSET);
  wire wr_temp_gain = i_wr && hit(wpg, wad, PAGE_16, ADDR_TEMPERATURE_GAIN);
  wire wr_temp_off = i_wr && hit(wpg, wad, PAGE_16, ADDR_TEMPERATURE_OFFSET);
  wire wr_gain = i_wr && hit(wpg, wad, PAGE_16, ADDR_CURRENT_GAIN);
  wire wr_scale = i_wr && hit(wpg, wad, PAGE_18, ADDR_CALIBRATION_SCALE);
  wire wr_zx_count = i_wr && hit(wpg, wad, PAGE_0, ADDR_ZERO_CROSS_COUNT);
  wire wr_vzx = i_wr && hit(wpg, wad, PAGE_18, ADDR_VOLTAGE_ZX_THRESHOLD);
  wire wr_izx = i_wr && hit(wpg, wad, PAGE_18, ADDR_CURRENT_ZX_THRESHOLD);

  // Unmapped reads return zero.
  wire [DATA_W-1:0] rd_mux =
    hit(i_rd_page, i_rd_addr, PAGE_16, ADDR_REACTIVE_POWER_OFFSET) ? reactive_power_offset_ff :
    hit(i_rd_page, i_rd_addr, PAGE_16, ADDR_CURRENT_AC_OFFSET) ? current_ac_offset_ff :
    hit(i_rd_page, i_rd_addr, PAGE_16, ADDR_TEMPERATURE_GAIN) ? temperature_gain_ff :
    hit(i_rd_page, i_rd_addr, PAGE_16, ADDR_TEMPERATURE_OFFSET) ? temperature_offset_ff :
    hit(i_rd_page, i_rd_addr, PAGE_16, ADDR_CURRENT_GAIN) ? current_gain_ff :
    hit(i_rd_page, i_rd_addr, PAGE_18, ADDR_CALIBRATION_SCALE) ? calibration_scale_ff :
    hit(i_rd_page, i_rd_addr, PAGE_0, ADDR_ZERO_CROSS_COUNT) ? zero_cross_count_ff :
    hit(i_rd_page, i_rd_addr, PAGE_18, ADDR_VOLTAGE_ZX_THRESHOLD) ? voltage_zero_cross_threshold_ff :
    hit(i_rd_page, i_rd_addr, PAGE_18, ADDR_CURRENT_ZX_THRESHOLD) ? current_zero_cross_threshold_ff :
    '0;

  // The reactive power sum wraps in 24 bits; the host keeps the offset sane.
  wire [DATA_W-1:0] nxt_reactive = i_reactive_power_raw + reactive_power_offset_ff;
  // The AC offset holds a squared noise level, so it is removed from the squared RMS, floored at zero.
  wire [DATA_W-1:0] nxt_rms_corr = (i_current_rms_sq > current_ac_offset_ff) ?
    i_current_rms_sq - current_ac_offset_ff : '0;
  wire signed [2*DATA_W:0] temp_prod =
    $signed(i_temperature_raw) * $signed({1'b0, temperature_gain_ff});
  wire [DATA_W-1:0] temp_scaled = temp_prod[TEMP_GAIN_FRAC +: DATA_W];
  wire [DATA_W-1:0] nxt_temp = temp_scaled + temperature_offset_ff;

  // Restoring division, one quotient bit per cycle, of scale shifted into 2.22 by the RMS result.
  wire [DATA_W:0] rem_shift = {remainder_ff[DATA_W-1:0], dividend_ff[DIV_W-1]};
  wire rem_ge = rem_shift >= {1'b0, i_current_rms_result};
  wire [DATA_W:0] nxt_remainder = rem_ge ? rem_shift - {1'b0, i_current_rms_result} : rem_shift;
  wire div_last = (bit_cnt_ff == 1);
  // A quotient of 4.0 or more, or a zero divisor, cannot be held and saturates.
  wire div_overflow = (i_current_rms_result == '0) || (quotient_ff[DIV_W-2:DATA_W-1] != '0);
  wire [DATA_W-1:0] div_result = div_overflow ? GAIN_MAX : {quotient_ff[DATA_W-2:0], rem_ge};
  wire cal_done = (state_ff == CAL_DIVIDE) && div_last;

  wire zx_last = i_zero_cross && (zx_seen_ff + 24'h000001 >= zero_cross_count_ff);

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      reactive_power_offset_ff <= RST_REACTIVE_POWER_OFFSET;
      current_ac_offset_ff <= RST_CURRENT_AC_OFFSET;
      temperature_gain_ff <= RST_TEMPERATURE_GAIN;
      temperature_offset_ff <= RST_TEMPERATURE_OFFSET;
      calibration_scale_ff <= RST_CALIBRATION_SCALE;
      zero_cross_count_ff <= RST_ZERO_CROSS_COUNT;
      voltage_zero_cross_threshold_ff <= RST_ZX_THRESHOLD;
      current_zero_cross_threshold_ff <= RST_ZX_THRESHOLD;
    end else begin
      if (wr_reactive_off) reactive_power_offset_ff <= i_wr_req.data;
      if (wr_ac_off) current_ac_offset_ff <= i_wr_req.data;
      if (wr_temp_gain) temperature_gain_ff <= i_wr_req.data;
      if (wr_temp_off) temperature_offset_ff <= i_wr_req.data;
      if (wr_scale) calibration_scale_ff <= i_wr_req.data;
      if (wr_zx_count) zero_cross_count_ff <= i_wr_req.data;
      if (wr_vzx) voltage_zero_cross_threshold_ff <= i_wr_req.data;
      if (wr_izx) current_zero_cross_threshold_ff <= i_wr_req.data;
    end
  end

  // The calibration result takes priority over a host write landing in the same cycle.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      current_gain_ff <= RST_CURRENT_GAIN;
    end else if (cal_done) begin
      current_gain_ff <= div_result;
    end else if (wr_gain) begin
      current_gain_ff <= i_wr_req.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_ff <= CAL_IDLE;
      dividend_ff <= '0;
      remainder_ff <= '0;
      quotient_ff <= '0;
      bit_cnt_ff <= '0;
    end else begin
      case (state_ff)
        CAL_IDLE: begin
          if (i_cal_gain_start) begin
            state_ff <= CAL_DIVIDE;
            dividend_ff <= {calibration_scale_ff, {GAIN_FRAC{1'b0}}};
            remainder_ff <= '0;
            quotient_ff <= '0;
            bit_cnt_ff <= DIV_W[$clog2(DIV_W+1)-1:0];
          end
        end
        CAL_DIVIDE: begin
          dividend_ff <= {dividend_ff[DIV_W-2:0], 1'b0};
          remainder_ff <= nxt_remainder;
          quotient_ff <= {quotient_ff[DIV_W-2:0], rem_ge};
          bit_cnt_ff <= bit_cnt_ff - 1'b1;
          if (div_last) state_ff <= CAL_IDLE;
        end
        default: state_ff <= CAL_IDLE;
      endcase
    end
  end

  // A completion in the clearing cycle keeps the flag set.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      data_ready_ff <= 1'b0;
    end else begin
      data_ready_ff <= cal_done || (data_ready_ff && !i_data_ready_clear);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      zx_seen_ff <= '0;
      freq_done_ff <= 1'b0;
    end else begin
      freq_done_ff <= zx_last;
      if (zx_last) zx_seen_ff <= '0;
      else if (i_zero_cross) zx_seen_ff <= zx_seen_ff + 24'h000001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rd_data_ff <= '0;
      rd_valid_ff <= 1'b0;
      o_reactive_power_average <= '0;
      o_current_rms_corrected <= '0;
      o_temperature_result <= '0;
      o_voltage_zx_enable <= 1'b0;
      o_current_zx_enable <= 1'b0;
    end else begin
      rd_valid_ff <= i_rd;
      if (i_rd) rd_data_ff <= rd_mux;
      o_reactive_power_average <= nxt_reactive;
      o_current_rms_corrected <= nxt_rms_corr;
      o_temperature_result <= nxt_temp;
      o_voltage_zx_enable <= $signed(i_voltage_peak) > $signed(voltage_zero_cross_threshold_ff);
      o_current_zx_enable <= $signed(i_current_peak) > $signed(current_zero_cross_threshold_ff);
    end
  end

  assign o_rd_data = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_current_gain = current_gain_ff;
  assign o_freq_window_done = freq_done_ff;
  assign o_cal_busy = (state_ff == CAL_DIVIDE);
  assign o_data_ready_flag = data_ready_ff;

endmodule : calibration_threshold_regs

// file: test/cal_regs_chk.sv
// Port checker for the calibration register bank, bound to its top module.
// Assumes one clock and a synchronous reset held for at least two cycles.
`timescale 1ns/100ps
module cal_regs_chk
  import cal_regs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] i_current_rms_sq,
  input wire logic [DATA_W-1:0] i_voltage_peak,
  input wire logic [DATA_W-1:0] i_current_peak,
  input wire logic i_zero_cross,
  input wire logic i_cal_gain_start,
  input wire logic i_data_ready_clear,
  input wire logic o_rd_valid,
  input wire logic [DATA_W-1:0] o_current_rms_corrected,
  input wire logic [DATA_W-1:0] o_current_gain,
  input wire logic o_voltage_zx_enable,
  input wire logic o_current_zx_enable,
  input wire logic o_freq_window_done,
  input wire logic o_cal_busy,
  input wire logic o_data_ready_flag
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  chk_read_answer: assert property (i_rd |=> o_rd_valid)
    else $error("read unanswered");
  chk_read_cause: assert property (o_rd_valid |-> $past(i_rd))
    else $error("stray read valid");
  chk_cal_length: assert property (i_cal_gain_start && !o_cal_busy |=> o_cal_busy [*8] ##38 o_cal_busy ##1 !o_cal_busy)
    else $error("calibration length wrong");
  chk_ready_on_done: assert property ($fell(o_cal_busy) |-> o_data_ready_flag)
    else $error("ready flag missing");
  chk_ready_sticky: assert property (o_data_ready_flag && !i_data_ready_clear |=> o_data_ready_flag)
    else $error("ready flag dropped");
  chk_gain_cause: assert property (!$stable(o_current_gain) |-> $past(i_wr) || $past(o_cal_busy))
    else $error("gain changed alone");
  chk_rms_floor: assert property (o_current_rms_corrected <= $past(i_current_rms_sq))
    else $error("rms correction grew");
  chk_vzx_negative: assert property (i_voltage_peak[DATA_W-1] |=> !o_voltage_zx_enable)
    else $error("voltage zx on negative peak");
  chk_izx_negative: assert property (i_current_peak[DATA_W-1] |=> !o_current_zx_enable)
    else $error("current zx on negative peak");
  chk_window_cause: assert property (o_freq_window_done |-> $past(i_zero_cross))
    else $error("window without crossing");
  cov_cal_done: cover property ($fell(o_cal_busy));
  cov_window: cover property (o_freq_window_done);
  cov_zx_both: cover property (o_voltage_zx_enable && o_current_zx_enable);
endmodule : cal_regs_chk
bind calibration_threshold_regs cal_regs_chk u_chk (
  .i_clk(i_clk),
  .i_rst_b(i_rst_b),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .i_current_rms_sq(i_current_rms_sq),
  .i_voltage_peak(i_voltage_peak),
  .i_current_peak(i_current_peak),
  .i_zero_cross(i_zero_cross),
  .i_cal_gain_start(i_cal_gain_start),
  .i_data_ready_clear(i_data_ready_clear),
  .o_rd_valid(o_rd_valid),
  .o_current_rms_corrected(o_current_rms_corrected),
  .o_current_gain(o_current_gain),
  .o_voltage_zx_enable(o_voltage_zx_enable),
  .o_current_zx_enable(o_current_zx_enable),
  .o_freq_window_done(o_freq_window_done),
  .o_cal_busy(o_cal_busy),
  .o_data_ready_flag(o_data_ready_flag)
);

// file: test/host_model.sv
// Host side of the register port: one-cycle write and read strobes.
// Assumes the bank answers a read one cycle after the strobe.
`timescale 1ns/100ps
module host_model
  import cal_regs_pkg::*;
(
  input wire logic i_clk,
  input wire logic [DATA_W-1:0] i_rd_data,
  output logic o_wr = 1'b0,
  output reg_write_t o_wr_req = '0,
  output logic o_rd = 1'b0,
  output logic [PAGE_W-1:0] o_rd_page = '0,
  output logic [ADDR_W-1:0] o_rd_addr = '0
);
  task automatic wr(input logic [PAGE_W-1:0] pg, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    @(negedge i_clk);
    // Page 18 holds the signed scale and thresholds, kept non-negative by the host.
    if (pg == PAGE_18) d[DATA_W-1] = 1'b0;
    if (pg == PAGE_0 && d == '0) d = 24'h000001;
    o_wr_req = '{pg, ad, d};
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    // Released lines carry the inverse so a late sample cannot match by luck.
    o_wr_req = ~o_wr_req;
  endtask : wr
  task automatic rd(input logic [PAGE_W-1:0] pg, input logic [ADDR_W-1:0] ad, output logic [DATA_W-1:0] q);
    @(negedge i_clk);
    {o_rd_page, o_rd_addr} = {pg, ad};
    o_rd = 1'b1;
    @(negedge i_clk);
    q = i_rd_data;
    o_rd = 1'b0;
    {o_rd_page, o_rd_addr} = ~{pg, ad};
  endtask : rd
endmodule : host_model

// file: test/tb.sv
// Self-checking bench for the calibration register bank.
// Assumes the host model for register access and the bound port checker.
`timescale 1ns/100ps
module tb;
  import cal_regs_pkg::*;
  // Order: reactive off, ac off, temp gain, temp off, current gain, scale, zx count, volt thr, cur thr.
  localparam logic [PAGE_W-1:0] PG [9] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h12, 8'h00, 8'h12, 8'h12};
  localparam logic [ADDR_W-1:0] AD [9] = '{6'h26, 6'h25, 6'h36, 6'h37, 6'h21, 6'h3f, 6'h37, 6'h3a, 6'h18};
  localparam logic [DATA_W-1:0] DV [9] = '{24'h000000, 24'h000000, 24'h06b716, 24'hd53998, 24'h400000,
    24'h4ccccc, 24'h000064, 24'h100000, 24'h100000};
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_wr, i_rd;
  reg_write_t i_wr_req;
  logic [PAGE_W-1:0] i_rd_page;
  logic [ADDR_W-1:0] i_rd_addr;
  logic [DATA_W-1:0] i_reactive_power_raw = '0, i_current_rms_sq = '0, i_current_rms_result = '0;
  logic [DATA_W-1:0] i_temperature_raw = '0, i_voltage_peak = 24'h800000, i_current_peak = 24'h800000;
  logic i_zero_cross = 1'b0, i_cal_gain_start = 1'b0, i_data_ready_clear = 1'b0;
  logic [DATA_W-1:0] o_rd_data, o_reactive_power_average, o_current_rms_corrected, o_temperature_result;
  logic [DATA_W-1:0] o_current_gain, q;
  logic o_rd_valid, o_voltage_zx_enable, o_current_zx_enable, o_freq_window_done, o_cal_busy, o_data_ready_flag;
  int fail_count = 0;
  int checks = 0;
  int n;
  calibration_threshold_regs i_dut (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_wr(i_wr),
    .i_wr_req(i_wr_req),
    .i_rd(i_rd),
    .i_rd_page(i_rd_page),
    .i_rd_addr(i_rd_addr),
    .i_reactive_power_raw(i_reactive_power_raw),
    .i_current_rms_sq(i_current_rms_sq),
    .i_current_rms_result(i_current_rms_result),
    .i_temperature_raw(i_temperature_raw),
    .i_voltage_peak(i_voltage_peak),
    .i_current_peak(i_current_peak),
    .i_zero_cross(i_zero_cross),
    .i_cal_gain_start(i_cal_gain_start),
    .i_data_ready_clear(i_data_ready_clear),
    .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid),
    .o_reactive_power_average(o_reactive_power_average),
    .o_current_rms_corrected(o_current_rms_corrected),
    .o_temperature_result(o_temperature_result),
    .o_current_gain(o_current_gain),
    .o_voltage_zx_enable(o_voltage_zx_enable),
    .o_current_zx_enable(o_current_zx_enable),
    .o_freq_window_done(o_freq_window_done),
    .o_cal_busy(o_cal_busy),
    .o_data_ready_flag(o_data_ready_flag)
  );
  host_model h (.i_clk(i_clk), .i_rd_data(o_rd_data), .o_wr(i_wr), .o_wr_req(i_wr_req), .o_rd(i_rd),
    .o_rd_page(i_rd_page), .o_rd_addr(i_rd_addr));
  task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic rdchk(input logic [PAGE_W-1:0] pg, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
    h.rd(pg, ad, q);
    chk("rd_valid", o_rd_valid, 1'b1);
    chk($sformatf("reg %h.%h", pg, ad), q, e);
  endtask : rdchk
  task automatic point(input logic [DATA_W-1:0] t, s, v, c);
    {i_temperature_raw, i_current_rms_sq, i_voltage_peak, i_current_peak} = {t, s, v, c};
    repeat (2) @(negedge i_clk);
  endtask : point
  initial forever #2 i_clk = ~i_clk;
  initial begin
    #80000;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (20) @(negedge i_clk);
    i_rst_b = 1'b1;
    for (int k = 0; k < 9; k++) rdchk(PG[k], AD[k], DV[k]);
    rdchk(8'h12, 6'h00, 24'h000000);
    for (int k = 0; k < 9; k++) h.wr(PG[k], AD[k], 24'h012345 + 24'(k) * 24'h010101);
    for (int k = 0; k < 9; k++) rdchk(PG[k], AD[k], 24'h012345 + 24'(k) * 24'h010101);
    i_rst_b = 1'b0;
    repeat (4) @(negedge i_clk);
    i_rst_b = 1'b1;
    for (int k = 0; k < 9; k++) rdchk(PG[k], AD[k], DV[k]);
    h.wr(PG[0], AD[0], 24'h000010);
    h.wr(PG[1], AD[1], 24'h000040);
    h.wr(PG[2], AD[2], 24'h020000);
    h.wr(PG[3], AD[3], 24'h000100);
    h.wr(PG[6], AD[6], 24'h000003);
    h.wr(PG[7], AD[7], 24'h200000);
    h.wr(PG[8], AD[8], 24'h300000);
    i_reactive_power_raw = 24'h000005;
    point(24'h001000, 24'h000100, 24'h280000, 24'h280000);
    chk("react_avg", o_reactive_power_average, 24'h000015);
    chk("temp", o_temperature_result, 24'h002100);
    chk("rms_corr", o_current_rms_corrected, 24'h0000c0);
    chk("vzx", o_voltage_zx_enable, 1'b1);
    chk("izx", o_current_zx_enable, 1'b0);
    point(24'hfff000, 24'h000020, 24'h200000, 24'h300001);
    chk("temp_neg", o_temperature_result, 24'hffe100);
    chk("rms_floor", o_current_rms_corrected, 24'h000000);
    chk("vzx_equal", o_voltage_zx_enable, 1'b0);
    chk("izx_above", o_current_zx_enable, 1'b1);
    // Both channels above threshold at once, and a squared RMS equal to the offset.
    point(24'h000000, 24'h000040, 24'h200001, 24'h300001);
    chk("temp_zero", o_temperature_result, 24'h000100);
    chk("rms_equal", o_current_rms_corrected, 24'h000000);
    chk("vzx_above", o_voltage_zx_enable, 1'b1);
    chk("izx_both", o_current_zx_enable, 1'b1);
    i_zero_cross = 1'b1;
    repeat (2) @(negedge i_clk);
    chk("win_early", o_freq_window_done, 1'b0);
    @(negedge i_clk);
    i_zero_cross = 1'b0;
    chk("win_done", o_freq_window_done, 1'b1);
    @(negedge i_clk);
    chk("win_pulse", o_freq_window_done, 1'b0);
    h.wr(PG[5], AD[5], 24'h200000);
    for (int k = 0; k < 2; k++) begin
      i_current_rms_result = k ? 24'h000000 : 24'h400000;
      @(negedge i_clk);
      i_cal_gain_start = 1'b1;
      n = 0;
      // A second start in mid-run must be ignored and leave the length alone.
      do begin
        @(negedge i_clk);
        n++;
        i_cal_gain_start = (n == 10);
      end while (o_cal_busy === 1'b1 && n < 60);
      // The loop also counts the first idle cycle after the busy span.
      chk("busy_len", 24'(n), 24'h00002f);
      chk("gain", o_current_gain, k ? 24'hffffff : 24'h200000);
      chk("rdy", o_data_ready_flag, 1'b1);
      i_data_ready_clear = 1'b1;
      @(negedge i_clk);
      i_data_ready_clear = 1'b0;
      chk("rdy_clr", o_data_ready_flag, 1'b0);
    end
    end_sim();
  end
endmodule : tb
